// >>> header_pkg.sv
// constants shared by the record header builder and its helpers
package header_pkg;
	// header size and byte offsets of each field, little-endian
	localparam int HDR_BYTES = 40;
	localparam logic [5:0] OFF_STATUS = 6'h00;
	localparam logic [5:0] OFF_TAG = 6'h01;
	localparam logic [5:0] OFF_CHAN = 6'h02;
	localparam logic [5:0] OFF_FMT = 6'h03;
	localparam logic [5:0] OFF_SERIAL = 6'h04;
	localparam logic [5:0] OFF_COUNT = 6'h08;
	localparam logic [5:0] OFF_PERIOD = 6'h0C;
	localparam logic [5:0] OFF_TRIG = 6'h10;
	localparam logic [5:0] OFF_START = 6'h18;
	localparam logic [5:0] OFF_LEN = 6'h20;
	localparam logic [5:0] OFF_GP = 6'h24;
	localparam logic [5:0] OFF_TSRST = 6'h26;
	localparam logic [5:0] LAST_BYTE = 6'h27;
	// status byte bit positions
	localparam int ST_OVR = 7;
	localparam int ST_FILL_LO = 4;
	localparam int ST_LOST_REC = 3;
	localparam int ST_LOST_START = 2;
	localparam int ST_LOST_MID = 1;
	localparam int ST_LOST_END = 0;
	// sample format codes
	localparam logic [7:0] FMT_16BIT = 8'h00;
	localparam logic [7:0] FMT_32BIT = 8'h01;
	// register word addresses (byte addresses)
	localparam logic [5:0] REG_CTRL = 6'h00;
	localparam logic [5:0] REG_SERIAL = 6'h04;
	localparam logic [5:0] REG_PERIOD = 6'h08;
	localparam logic [5:0] REG_GP = 6'h0C;
	localparam logic [5:0] REG_COUNT = 6'h10;
	localparam logic [5:0] REG_TSRST = 6'h14;
	localparam logic [5:0] REG_IRQ_ST = 6'h18;
	localparam logic [5:0] REG_IRQ_MASK = 6'h1C;
	// reset values
	localparam logic [31:0] SERIAL_RST = 32'h00000000;
	localparam logic [31:0] PERIOD_RST = 32'h00000001;
	localparam logic [7:0] TAG_RST = 8'h00;
	// interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_LOST = 1;
	localparam int IRQ_OVR = 2;
	// builder states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CAPTURE = 2'b01,
		ST_SEND = 2'b11
	} build_state_t;
endpackage : header_pkg

// >>> fill_peak.sv
// peak buffer-fill tracker producing the three-bit occupancy code
`timescale 1ns/1ps
module fill_peak import header_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic [7:0] fill_pct,
	output logic [2:0] peak_code
);
	logic [2:0] now_code;
	// eighth steps
	// eighths of 100 percent; 8 codes of 12.5 each, 2/25 keeps it integral
	always_comb begin
		if (fill_pct >= 8'd100) begin
			now_code = 3'h7;
		end else begin
			now_code = 3'((16'(fill_pct) * 16'd2) / 16'd25);
		end
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			peak_code <= 3'h0;
		end else if (start) begin
			peak_code <= now_code;
		end else if (now_code > peak_code) begin
			peak_code <= now_code;
		end
	end
endmodule : fill_peak

// >>> header_serializer.sv
// byte-wise little-endian serialiser for the 40-byte header image
`timescale 1ns/1ps
module header_serializer import header_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [319:0] image,
	input wire logic out_ready,
	output logic out_valid,
	output logic [7:0] out_data,
	output logic out_last,
	output logic busy
);
	logic [319:0] image_r;
	logic [5:0] idx_r;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			image_r <= '0;
			idx_r <= 6'h00;
			busy <= 1'b0;
		end else if (load && !busy) begin
			image_r <= image;
			idx_r <= 6'h00;
			busy <= 1'b1;
		end else if (busy && out_ready) begin
			image_r <= {8'h00, image_r[319:8]};
			idx_r <= idx_r + 6'h01;
			if (idx_r == LAST_BYTE) begin
				busy <= 1'b0;
			end
		end
	end
	assign out_valid = busy;
	assign out_data = image_r[7:0];
	assign out_last = busy && (idx_r == LAST_BYTE);
endmodule : header_serializer

// >>> record_header_builder.sv
// record header builder: captures record metadata and emits a 40-byte header
// Operation
// - emit one forty-byte header per record, apart from sample data
// - first byte is status: overflow, fill level, lost-data bits
// - one byte user tag, set by software
// - one byte channel, low codes physical, rest synthetic
// - format byte is 0 for 16-bit, 1 for 32-bit samples
// - 32-bit unit serial number field
// - 32-bit record counter since power-up, never cleared by restarts
// - signed 32-bit sample period in 125 ps units
// - signed 64-bit trigger time in 125 ps units
// - signed 64-bit trigger-to-first-sample offset in 125 ps units
// - 32-bit record length counted in samples
// - 16-bit count of timestamp counter resets
// - overflow bit set by any saturation, held until record ends
// - three-bit fill code in 12.5 percent steps
// - fill code reports peak occupancy over the record
// - four lost-data bits: record, start, middle, end
// - lost start sets its bit and blanks timestamp fields
// - lost middle set by any missing section inside the body
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module record_header_builder import header_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	// avalon-mm slave
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// acquisition engine
	input wire logic rec_start,
	input wire logic rec_end,
	input wire logic [7:0] rec_channel,
	input wire logic rec_wide,
	input wire logic [63:0] trigger_time,
	input wire logic [63:0] rec_offset,
	input wire logic sample_valid,
	input wire logic sample_sat,
	input wire logic [7:0] fill_pct,
	input wire logic lost_record,
	input wire logic lost_start,
	input wire logic lost_mid,
	input wire logic lost_end,
	input wire logic ts_reset,
	// header stream to the transfer path
	output logic hdr_valid,
	output logic [7:0] hdr_data,
	output logic hdr_last,
	input wire logic hdr_ready,
	output logic irq
);
	build_state_t state_r;
	logic [7:0] tag_r;
	logic [31:0] serial_r;
	logic [31:0] period_r;
	logic [15:0] gp_r;
	logic [31:0] count_r;
	logic [15:0] tsrst_r;
	logic [31:0] len_r;
	logic ovr_r;
	logic [3:0] lost_r;
	logic [7:0] chan_r;
	logic fmt_r;
	logic [63:0] trig_r;
	logic [63:0] offs_r;
	logic [2:0] irq_st_r;
	logic [2:0] irq_mask_r;
	logic [2:0] peak_code;
	logic ser_busy;
	logic load;
	logic [7:0] status_byte;
	logic [319:0] image;
	logic rd_ack_r;
	logic wr_ack_r;
	logic rd_st;
	logic [2:0] ev;

	// one wait cycle per access keeps the read mux registered
	assign waitrequest = (read && !rd_ack_r) || (write && !wr_ack_r);
	assign rd_st = read && rd_ack_r && (address == REG_IRQ_ST);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rd_ack_r <= 1'b0;
			wr_ack_r <= 1'b0;
		end else begin
			rd_ack_r <= read && !rd_ack_r;
			wr_ack_r <= write && !wr_ack_r;
		end
	end

	// software tag
	// ctrl byte 0 holds the tag written over the Avalon-MM bus at REG_CTRL
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tag_r <= TAG_RST;
			serial_r <= SERIAL_RST;
			period_r <= PERIOD_RST;
			gp_r <= 16'h0000;
			irq_mask_r <= 3'h0;
		end else if (write && wr_ack_r) begin
			case (address)
				REG_CTRL: begin
					if (byteenable[0]) tag_r <= writedata[7:0];
				end
				REG_SERIAL: begin
					for (int i = 0; i < 4; i++) begin
						if (byteenable[i]) serial_r[8*i +: 8] <= writedata[8*i +: 8];
					end
				end
				REG_PERIOD: begin
					for (int i = 0; i < 4; i++) begin
						if (byteenable[i]) period_r[8*i +: 8] <= writedata[8*i +: 8];
					end
				end
				REG_GP: begin
					if (byteenable[0]) gp_r[7:0] <= writedata[7:0];
					if (byteenable[1]) gp_r[15:8] <= writedata[15:8];
				end
				REG_IRQ_MASK: begin
					if (byteenable[0]) irq_mask_r <= writedata[2:0];
				end
				default: begin
				end
			endcase
		end
	end

	// registered read mux; unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (!resetn) begin
			readdata <= 32'h00000000;
		end else if (read && !rd_ack_r) begin
			case (address)
				REG_CTRL: readdata <= {24'h000000, tag_r};
				REG_SERIAL: readdata <= serial_r;
				REG_PERIOD: readdata <= period_r;
				REG_GP: readdata <= {16'h0000, gp_r};
				REG_COUNT: readdata <= count_r;
				REG_TSRST: readdata <= {16'h0000, tsrst_r};
				REG_IRQ_ST: readdata <= {29'h00000000, irq_st_r};
				REG_IRQ_MASK: readdata <= {29'h00000000, irq_mask_r};
				default: readdata <= 32'h00000000;
			endcase
		end
	end

	// record sequencer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (rec_start) state_r <= ST_CAPTURE;
				end
				ST_CAPTURE: begin
					// waits for the previous header to drain before loading
					if (rec_end && !ser_busy) state_r <= ST_SEND;
				end
				ST_SEND: begin
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
	// rec_end must be held until taken when the serialiser is still busy
	assign load = (state_r == ST_SEND);

	// per-record metadata latched at the start
	always_ff @(posedge clk) begin
		if (!resetn) begin
			chan_r <= 8'h00;
			fmt_r <= 1'b0;
			trig_r <= 64'h0;
			offs_r <= 64'h0;
		end else if (state_r == ST_IDLE && rec_start) begin
			chan_r <= rec_channel;
			fmt_r <= rec_wide;
			trig_r <= lost_start ? 64'h0 : trigger_time;
			offs_r <= lost_start ? 64'h0 : rec_offset;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			len_r <= 32'h0;
		end else if (state_r == ST_IDLE && rec_start) begin
			len_r <= {31'h0, sample_valid};
		end else if (state_r == ST_CAPTURE && sample_valid) begin
			len_r <= len_r + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ovr_r <= 1'b0;
		end else if (state_r == ST_IDLE && rec_start) begin
			ovr_r <= sample_sat;
		end else if (state_r == ST_CAPTURE && sample_sat) begin
			ovr_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			lost_r <= 4'h0;
		end else if (state_r == ST_IDLE && rec_start) begin
			lost_r <= {lost_record, lost_start, lost_mid, lost_end};
		end else if (state_r == ST_CAPTURE) begin
			lost_r <= lost_r | {lost_record, lost_start, lost_mid, lost_end};
		end
	end

	// power-up counter
	// only a reset clears it; an acquisition restart does not touch it
	always_ff @(posedge clk) begin
		if (!resetn) begin
			count_r <= 32'h0;
		end else if (load) begin
			count_r <= count_r + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tsrst_r <= 16'h0;
		end else if (ts_reset) begin
			tsrst_r <= tsrst_r + 16'h1;
		end
	end

	always_comb begin
		status_byte = 8'h00;
		status_byte[ST_OVR] = ovr_r;
		status_byte[ST_FILL_LO +: 3] = peak_code;
		status_byte[ST_LOST_REC] = lost_r[3];
		status_byte[ST_LOST_START] = lost_r[2];
		status_byte[ST_LOST_MID] = lost_r[1];
		status_byte[ST_LOST_END] = lost_r[0];
	end

	always_comb begin
		image = '0;
		image[8*OFF_STATUS +: 8] = status_byte;
		image[8*OFF_TAG +: 8] = tag_r;
		image[8*OFF_CHAN +: 8] = chan_r;
		image[8*OFF_FMT +: 8] = fmt_r ? FMT_32BIT : FMT_16BIT;
		image[8*OFF_SERIAL +: 32] = serial_r;
		image[8*OFF_COUNT +: 32] = count_r;
		image[8*OFF_PERIOD +: 32] = period_r;
		// times withheld
		// a start loss flagged mid-record still hides the latched times
		image[8*OFF_TRIG +: 64] = lost_r[2] ? 64'h0 : trig_r;
		image[8*OFF_START +: 64] = lost_r[2] ? 64'h0 : offs_r;
		image[8*OFF_LEN +: 32] = len_r;
		image[8*OFF_GP +: 16] = gp_r;
		image[8*OFF_TSRST +: 16] = tsrst_r;
	end

	fill_peak u_fill (
		.clk(clk),
		.resetn(resetn),
		.start(state_r == ST_IDLE && rec_start),
		.fill_pct(fill_pct),
		.peak_code(peak_code)
	);

	header_serializer u_ser (
		.clk(clk),
		.resetn(resetn),
		.load(load),
		.image(image),
		.out_ready(hdr_ready),
		.out_valid(hdr_valid),
		.out_data(hdr_data),
		.out_last(hdr_last),
		.busy(ser_busy)
	);

	// interrupt events; set wins over the clear-on-read
	// only bits already captured in readdata clear, so a later event is not lost
	assign ev = {load && ovr_r, load && (lost_r != 4'h0), load};
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_st_r <= 3'h0;
		end else begin
			irq_st_r <= (irq_st_r & ~(rd_st ? readdata[2:0] : 3'h0)) | ev;
		end
	end
	assign irq = |(irq_st_r & irq_mask_r);

	// assertions
	logic [5:0] beat_cnt;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			beat_cnt <= 6'h0;
		end else if (hdr_valid && hdr_ready) begin
			beat_cnt <= hdr_last ? 6'h0 : beat_cnt + 6'h1;
		end
	end
	header_len_a: assert property (@(posedge clk) disable iff (!resetn)
		hdr_valid && hdr_ready && hdr_last |-> beat_cnt == 6'd39)
		else $error("header not forty bytes");
	counter_step_a: assert property (@(posedge clk) disable iff (!resetn)
		load |=> count_r == $past(count_r) + 32'h1)
		else $error("record counter did not step");
	ovr_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		state_r == ST_CAPTURE && sample_sat |=> ovr_r [*2])
		else $error("overflow flag dropped");
	ts_blank_a: assert property (@(posedge clk) disable iff (!resetn)
		state_r == ST_IDLE && rec_start && lost_start |=> trig_r == 64'h0 && lost_r[2])
		else $error("lost start kept timestamp");
	ts_field_blank_a: assert property (@(posedge clk) disable iff (!resetn)
		load && lost_r[2] |->
		image[8*OFF_TRIG +: 64] == 64'h0 && image[8*OFF_START +: 64] == 64'h0)
		else $error("lost start header kept times");
	fill_peak_a: assert property (@(posedge clk) disable iff (!resetn)
		state_r == ST_CAPTURE && !$rose(state_r == ST_CAPTURE) |=> peak_code >= $past(peak_code))
		else $error("fill peak decreased");
	first_byte_a: assert property (@(posedge clk) disable iff (!resetn)
		load |=> hdr_valid && hdr_data == $past(status_byte))
		else $error("status not first byte");
	tsrst_step_a: assert property (@(posedge clk) disable iff (!resetn)
		ts_reset |=> tsrst_r == $past(tsrst_r) + 16'h1)
		else $error("reset count did not step");
	fmt_code_a: assert property (@(posedge clk) disable iff (!resetn)
		image[8*OFF_FMT +: 8] == {7'h00, fmt_r})
		else $error("bad format code");
endmodule : record_header_builder

// >>> header_sink.sv
// host transfer path model that collects one header image
`timescale 1ns/1ps
module header_sink (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clear,
	input wire logic stall,
	input wire logic hdr_valid,
	input wire logic [7:0] hdr_data,
	input wire logic hdr_last,
	output logic hdr_ready,
	output logic [319:0] got_img,
	output logic [6:0] got_n,
	output logic [6:0] last_pos
);
	logic tog_r;
	// slow host takes a byte only every other cycle
	always_ff @(posedge clk) begin
		tog_r <= ~tog_r & resetn;
	end
	assign hdr_ready = stall ? tog_r : 1'b1;
	// store each accepted byte at its place, byte 0 first
	always_ff @(posedge clk) begin
		if (!resetn || clear) begin
			got_n <= 7'h00;
			last_pos <= 7'h7F;
		end else if (hdr_valid && hdr_ready) begin
			if (got_n < 7'h28) got_img[8 * got_n +: 8] <= hdr_data;
			got_n <= got_n + 7'h01;
			if (hdr_last) last_pos <= got_n;
		end
	end
endmodule : header_sink

// >>> tb_top.sv
// self-checking bench for the record header builder
`timescale 1ns/1ps
module tb_top;
	import header_pkg::*;
	logic clk, resetn, read, write, irq, hdr_valid, hdr_last, hdr_ready, clear, stall;
	logic [5:0] address;
	logic [31:0] writedata, readdata, rd;
	logic [3:0] byteenable, lost;
	logic waitrequest, rec_start, rec_end, rec_wide, sample_valid, sample_sat, ts_reset;
	logic [7:0] rec_channel, fill_pct, hdr_data, tag_v;
	logic [63:0] trigger_time, rec_offset;
	logic [319:0] got_img, ex;
	logic [6:0] got_n, last_pos;
	logic [31:0] ser_v, per_v, rcnt;
	logic [15:0] gp_v, tsr;
	int failures = 0;
	int checks = 0;
	record_header_builder u_dut (.clk(clk), .resetn(resetn), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .rec_start(rec_start), .rec_end(rec_end),
		.rec_channel(rec_channel), .rec_wide(rec_wide), .trigger_time(trigger_time),
		.rec_offset(rec_offset), .sample_valid(sample_valid), .sample_sat(sample_sat),
		.fill_pct(fill_pct), .lost_record(lost[3]), .lost_start(lost[2]), .lost_mid(lost[1]),
		.lost_end(lost[0]), .ts_reset(ts_reset), .hdr_valid(hdr_valid), .hdr_data(hdr_data),
		.hdr_last(hdr_last), .hdr_ready(hdr_ready), .irq(irq));
	header_sink u_sink (.clk(clk), .resetn(resetn), .clear(clear), .stall(stall),
		.hdr_valid(hdr_valid), .hdr_data(hdr_data), .hdr_last(hdr_last), .hdr_ready(hdr_ready),
		.got_img(got_img), .got_n(got_n), .last_pos(last_pos));
	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task give_verdict;
		if (failures == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one bus access; held until waitrequest is seen low at an edge
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		@(posedge clk);
		address <= a;
		read <= ~wr;
		write <= wr;
		writedata <= d;
		byteenable <= be;
		n = 0;
		@(posedge clk);
		while (waitrequest !== 1'b0) begin
			@(posedge clk);
			n++;
		end
		chk("wait cycles", 64'h1, 64'(n));
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(what, exp, rd);
	endtask : rd_chk
	// one record; the fill peak lasts a single cycle, saturation too
	task run_rec(input logic [7:0] ch, input logic wide, input logic [63:0] trig, off,
		input int n, input logic [3:0] lb, input logic [7:0] pk, input logic sat);
		int k;
		@(posedge clk);
		clear <= 1'b1;
		rec_start <= 1'b1;
		rec_channel <= ch;
		rec_wide <= wide;
		trigger_time <= trig;
		rec_offset <= off;
		sample_valid <= 1'b1;
		fill_pct <= 8'h0A;
		lost <= lb; // flags at start and again mid-record
		@(posedge clk);
		clear <= 1'b0;
		rec_start <= 1'b0;
		lost <= lb;
		fill_pct <= pk;
		sample_sat <= sat;
		@(posedge clk);
		lost <= 4'h0;
		sample_sat <= 1'b0;
		fill_pct <= 8'h05;
		trigger_time <= ~trig;
		rec_offset <= ~off;
		repeat (n - 2) @(posedge clk);
		sample_valid <= 1'b0;
		rec_end <= 1'b1;
		for (k = 0; k < 100 && hdr_valid !== 1'b1; k++) @(posedge clk);
		rec_end <= 1'b0;
		for (k = 0; k < 300 && got_n < 7'h28; k++) @(posedge clk);
		repeat (4) @(posedge clk);
		ex = {tsr, gp_v, 32'(n), lb[2] ? 64'h0 : off, lb[2] ? 64'h0 : trig, per_v, rcnt,
			ser_v, wide ? FMT_32BIT : FMT_16BIT, ch, tag_v,
			sat, pk >= 8'h64 ? 3'h7 : 3'(pk * 2 / 25), lb};
		chk("byte count", 64'h28, 64'(got_n));
		chk("last position", 64'h27, 64'(last_pos));
		chk("status", 64'(ex[7:0]), 64'(got_img[7:0]));
		chk("user tag", 64'(ex[15:8]), 64'(got_img[15:8]));
		chk("channel", 64'(ex[23:16]), 64'(got_img[23:16]));
		chk("format", 64'(ex[31:24]), 64'(got_img[31:24]));
		chk("serial", 64'(ex[63:32]), 64'(got_img[63:32]));
		chk("record count", 64'(ex[95:64]), 64'(got_img[95:64]));
		chk("period", 64'(ex[127:96]), 64'(got_img[127:96]));
		chk("trigger time", ex[191:128], got_img[191:128]);
		chk("start offset", ex[255:192], got_img[255:192]);
		chk("length", 64'(ex[287:256]), 64'(got_img[287:256]));
		chk("general field", 64'(ex[303:288]), 64'(got_img[303:288]));
		chk("reset count", 64'(ex[319:304]), 64'(got_img[319:304]));
		rcnt = rcnt + 32'h1;
	endtask : run_rec
	task reg_defaults;
		rd_chk("period reset", REG_PERIOD, PERIOD_RST);
		rd_chk("serial reset", REG_SERIAL, SERIAL_RST);
		rd_chk("tag reset", REG_CTRL, 32'(TAG_RST));
		rd_chk("count reset", REG_COUNT, 32'h0);
		rd_chk("unmapped read", 6'h20, 32'h0);
		bus(1'b1, REG_PERIOD, 32'hFFFFFF40, 4'h1);
		rd_chk("period lane", REG_PERIOD, 32'h00000040);
	endtask : reg_defaults
	task setup_regs;
		tag_v = 8'hA5;
		ser_v = 32'h00C0FFEE;
		per_v = 32'hFFFFFFF8;
		gp_v = 16'hBEEF;
		bus(1'b1, REG_CTRL, 32'(tag_v), 4'hF);
		bus(1'b1, REG_SERIAL, ser_v, 4'hF);
		bus(1'b1, REG_PERIOD, per_v, 4'hF);
		bus(1'b1, REG_GP, 32'(gp_v), 4'hF);
		bus(1'b1, REG_IRQ_MASK, 32'h7, 4'hF);
	endtask : setup_regs
	// saturation, peak fill, wide format, interrupt on done and overflow
	task first_record;
		run_rec(8'h03, 1'b1, 64'h0123456789ABCDEF, 64'hFFFFFFFFFFFFFFF0, 6, 4'h0, 8'h3C, 1'b1);
		repeat (2) @(posedge clk);
		chk("irq raised", 64'h1, 64'(irq));
		rd_chk("irq status", REG_IRQ_ST, 32'h5);
		repeat (2) @(posedge clk);
		chk("irq cleared", 64'h0, 64'(irq));
		bus(1'b1, REG_COUNT, 32'h000000FF, 4'hF);
		rd_chk("count read only", REG_COUNT, rcnt);
	endtask : first_record
	// lost start blanks times; slow host; masked interrupt
	task second_record;
		bus(1'b1, REG_IRQ_MASK, 32'h0, 4'hF);
		repeat (2) begin
			@(posedge clk);
			ts_reset <= 1'b1;
			@(posedge clk);
			ts_reset <= 1'b0;
		end
		tsr = 16'h2;
		rd_chk("reset count reg", REG_TSRST, 32'h2);
		stall <= 1'b1;
		run_rec(8'hF0, 1'b0, 64'h1000, 64'h20, 3, 4'h6, 8'h64, 1'b0);
		stall <= 1'b0;
		chk("irq masked", 64'h0, 64'(irq));
		bus(1'b1, REG_IRQ_MASK, 32'h2, 4'hF);
		repeat (2) @(posedge clk);
		chk("irq unmasked", 64'h1, 64'(irq));
		rd_chk("irq status lost", REG_IRQ_ST, 32'h3);
		repeat (2) @(posedge clk);
		chk("irq after read", 64'h0, 64'(irq));
	endtask : second_record
	// reset, then scenarios in order
	initial begin
		resetn = 1'b0;
		{read, write, rec_start, rec_end, rec_wide, sample_valid, sample_sat} = 7'h00;
		{ts_reset, clear, stall} = 3'h0;
		address = 6'h00;
		writedata = 32'h0;
		byteenable = 4'hF;
		rec_channel = 8'h00;
		fill_pct = 8'h00;
		lost = 4'h0;
		trigger_time = 64'h0;
		rec_offset = 64'h0;
		rcnt = 32'h0;
		tsr = 16'h0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		reg_defaults();
		setup_regs();
		first_record();
		second_record();
		give_verdict();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		give_verdict();
	end
endmodule : tb_top
